// >>> common/piamp_cfg.svh
// Offsets, field positions, reset values and timing for the port registers
`ifndef PIAMP_CFG_SVH
`define PIAMP_CFG_SVH

`define PIAMP_OFF_CMD 12'h000
`define PIAMP_OFF_MIRROR 12'h004
`define PIAMP_OFF_PRIO 12'h008
`define PIAMP_OFF_DEFPRIO 12'h00c
`define PIAMP_OFF_BYTE_EN 12'h010
`define PIAMP_OFF_DATA0 12'h020
`define PIAMP_DATA_WORDS 4

`define PIAMP_CMD_WS_BIT 6
`define PIAMP_CMD_RS_BIT 5
`define PIAMP_CMD_DIR_BIT 4
`define PIAMP_CMD_IDX_MSB 3
`define PIAMP_CMD_RST 8'h60
`define PIAMP_CMD_WMASK 8'h1f

`define PIAMP_MIR_RX_BIT 6
`define PIAMP_MIR_TX_BIT 5
`define PIAMP_MIR_SNIF_BIT 1
`define PIAMP_MIR_RST 8'h00
`define PIAMP_MIR_WMASK 8'h62

`define PIAMP_PRI_HI_BIT 7
`define PIAMP_PRI_OR_BIT 6
`define PIAMP_PRI_MAC_BIT 4
`define PIAMP_PRI_VLAN_BIT 3
`define PIAMP_PRI_TAG_BIT 2
`define PIAMP_PRI_DSCP_BIT 1
`define PIAMP_PRI_ACL_BIT 0
`define PIAMP_PRI_RST 8'h00
`define PIAMP_PRI_WMASK 8'hdf

`define PIAMP_DEFPRIO_RST 3'h0
`define PIAMP_BYTE_EN_RST 16'h0000
`define PIAMP_ACL_OP_CYCLES 3'h4

`endif

// >>> common/piamp_pkg.sv
// Types used by the port register bank for its table sequencer and register state
package piamp_pkg;

    typedef enum logic [1:0] {
        PIAMP_IDLE = 2'b00,
        PIAMP_RUN = 2'b01,
        PIAMP_DONE = 2'b11
    } piamp_acl_state_t;

    typedef struct packed {
        piamp_acl_state_t st;
        logic [2:0] op_cnt;
        logic op_dir;
        logic [3:0] op_idx;
        logic [7:0] cmd;
        logic [7:0] mirror;
        logic [7:0] prio_ctl;
        logic [2:0] def_prio;
        logic [15:0] byte_en;
        logic [127:0] data;
        logic [15:0][127:0] acl_mem;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic rx_mon;
        logic tx_mon;
        logic sniffer;
        logic [2:0] pkt_prio;
        logic pkt_prio_valid;
    } piamp_state_t;

endpackage : piamp_pkg

// >>> src/piamp_classify.sv
// Ingress priority selection among enabled classifier results
`timescale 1ns/1ps
`include "piamp_cfg.svh"

module piamp_classify (
    // Control
    input wire logic [7:0] ctl,
    input wire logic [2:0] def_prio,
    // Classifier results
    input wire logic mac_valid,
    input wire logic [2:0] mac_prio,
    input wire logic vlan_valid,
    input wire logic [2:0] vlan_prio,
    input wire logic tag_valid,
    input wire logic [2:0] tag_prio,
    input wire logic dscp_valid,
    input wire logic [2:0] dscp_prio,
    input wire logic acl_valid,
    input wire logic [2:0] acl_prio,
    // Result
    output logic [2:0] prio
);

    function automatic logic [2:0] max3(input logic [2:0] a,
                                        input logic [2:0] b);
        return (a > b) ? a : b;
    endfunction : max3

    logic [4:0] use_v;
    logic [2:0] pr [5];

    always_comb begin
        use_v[4] = mac_valid & ctl[`PIAMP_PRI_MAC_BIT];
        use_v[3] = vlan_valid & ctl[`PIAMP_PRI_VLAN_BIT];
        use_v[2] = tag_valid & ctl[`PIAMP_PRI_TAG_BIT];
        use_v[1] = dscp_valid & ctl[`PIAMP_PRI_DSCP_BIT];
        use_v[0] = acl_valid & ctl[`PIAMP_PRI_ACL_BIT];
        pr[4] = mac_prio;
        pr[3] = vlan_prio;
        pr[2] = tag_prio;
        pr[1] = dscp_prio;
        pr[0] = acl_prio;
    end

    always_comb begin
        prio = def_prio;
        if (use_v != 5'h00) begin
            if (ctl[`PIAMP_PRI_HI_BIT]) begin
                prio = 3'h0;
                for (int i = 0; i < 5; i++) begin
                    if (use_v[i]) begin
                        prio = max3(prio, pr[i]);
                    end
                end
            end else if (ctl[`PIAMP_PRI_OR_BIT]) begin
                prio = 3'h0;
                for (int i = 0; i < 5; i++) begin
                    if (use_v[i]) begin
                        prio = prio | pr[i];
                    end
                end
            end else begin
                // Fixed precedence: ACL first, MAC last
                for (int i = 4; i >= 0; i--) begin
                    if (use_v[i]) begin
                        prio = pr[i];
                    end
                end
            end
        end
    end

endmodule : piamp_classify

// >>> src/piamp_regs.sv
// Per-port ACL access, mirroring and priority control registers on APB
`timescale 1ns/1ps
`include "piamp_cfg.svh"

module piamp_regs (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Mirroring
    input wire logic mirror_global_en,
    input wire logic rx_pkt,
    input wire logic tx_pkt,
    output logic rx_monitored,
    output logic tx_monitored,
    output logic sniffer_port_en,
    // Ingress classification
    input wire logic ingress_pkt,
    input wire logic mac_valid,
    input wire logic [2:0] mac_prio,
    input wire logic vlan_valid,
    input wire logic [2:0] vlan_prio,
    input wire logic tag_valid,
    input wire logic [2:0] tag_prio,
    input wire logic dscp_valid,
    input wire logic [2:0] dscp_prio,
    input wire logic acl_valid,
    input wire logic [2:0] acl_prio,
    output logic [2:0] pkt_prio,
    output logic pkt_prio_valid
);

    piamp_pkg::piamp_state_t s_reg;
    piamp_pkg::piamp_state_t s_next;
    logic [2:0] class_prio;
    logic setup;
    logic wr_acc;

    // Keeps old bytes where the enable is clear
    function automatic logic [127:0] merge(input logic [127:0] old_v,
                                           input logic [127:0] new_v,
                                           input logic [15:0] be);
        logic [127:0] r;
        r = old_v;
        for (int i = 0; i < 16; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return r;
    endfunction : merge

    function automatic logic mapped(input logic [11:0] a);
        logic hit;
        hit = (a == `PIAMP_OFF_CMD) || (a == `PIAMP_OFF_MIRROR) ||
              (a == `PIAMP_OFF_PRIO) || (a == `PIAMP_OFF_DEFPRIO) ||
              (a == `PIAMP_OFF_BYTE_EN);
        for (int k = 0; k < `PIAMP_DATA_WORDS; k++) begin
            hit = hit || (a == `PIAMP_OFF_DATA0 + 12'(4*k));
        end
        return hit;
    endfunction : mapped

    piamp_classify u_classify (
        .ctl(s_reg.prio_ctl),
        .def_prio(s_reg.def_prio),
        .mac_valid(mac_valid),
        .mac_prio(mac_prio),
        .vlan_valid(vlan_valid),
        .vlan_prio(vlan_prio),
        .tag_valid(tag_valid),
        .tag_prio(tag_prio),
        .dscp_valid(dscp_valid),
        .dscp_prio(dscp_prio),
        .acl_valid(acl_valid),
        .acl_prio(acl_prio),
        .prio(class_prio)
    );

    assign setup = psel && !penable;
    // Access phase is exactly the cycle after setup, so s_reg.pready marks it
    assign wr_acc = psel && penable && pwrite && s_reg.pready;

    always_comb begin
        s_next = s_reg;
        s_next.pready = 1'b0;
        s_next.pslverr = 1'b0;

        // Read data is prepared in the setup cycle to keep outputs registered
        if (setup) begin
            s_next.pready = 1'b1;
            s_next.pslverr = !mapped(paddr);
            s_next.prdata = 32'h0000_0000;
            if (!pwrite) begin
                case (paddr)
                    `PIAMP_OFF_CMD: s_next.prdata[7:0] = s_reg.cmd;
                    `PIAMP_OFF_MIRROR: s_next.prdata[7:0] = s_reg.mirror;
                    `PIAMP_OFF_PRIO: s_next.prdata[7:0] = s_reg.prio_ctl;
                    `PIAMP_OFF_DEFPRIO: s_next.prdata[2:0] = s_reg.def_prio;
                    `PIAMP_OFF_BYTE_EN: s_next.prdata[15:0] = s_reg.byte_en;
                    default: begin
                        for (int k = 0; k < `PIAMP_DATA_WORDS; k++) begin
                            if (paddr == `PIAMP_OFF_DATA0 + 12'(4*k)) begin
                                s_next.prdata = s_reg.data[96-32*k +: 32];
                            end
                        end
                    end
                endcase
            end
        end

        // Table access sequencer
        case (s_reg.st)
            piamp_pkg::PIAMP_IDLE: begin
                s_next.op_cnt = `PIAMP_ACL_OP_CYCLES;
            end
            piamp_pkg::PIAMP_RUN: begin
                if (s_reg.op_cnt == 3'h1) begin
                    s_next.st = piamp_pkg::PIAMP_DONE;
                end else begin
                    s_next.op_cnt = s_reg.op_cnt - 3'h1;
                end
            end
            piamp_pkg::PIAMP_DONE: begin
                if (s_reg.op_dir) begin
                    s_next.acl_mem[s_reg.op_idx] = merge(
                        s_reg.acl_mem[s_reg.op_idx], s_reg.data,
                        s_reg.byte_en);
                    s_next.cmd[`PIAMP_CMD_WS_BIT] = 1'b1;
                end else begin
                    s_next.data = merge(s_reg.data,
                        s_reg.acl_mem[s_reg.op_idx], s_reg.byte_en);
                    s_next.cmd[`PIAMP_CMD_RS_BIT] = 1'b1;
                end
                s_next.st = piamp_pkg::PIAMP_IDLE;
            end
            default: s_next.st = piamp_pkg::PIAMP_IDLE;
        endcase

        // Register writes; status bits are read-only
        if (wr_acc) begin
            case (paddr)
                `PIAMP_OFF_CMD: begin
                    if (pstrb[0]) begin
                        s_next.cmd = (s_next.cmd & ~`PIAMP_CMD_WMASK) |
                            (pwdata[7:0] & `PIAMP_CMD_WMASK);
                    end
                end
                `PIAMP_OFF_MIRROR: begin
                    if (pstrb[0]) begin
                        s_next.mirror = pwdata[7:0] & `PIAMP_MIR_WMASK;
                    end
                end
                `PIAMP_OFF_PRIO: begin
                    if (pstrb[0]) begin
                        s_next.prio_ctl = pwdata[7:0] & `PIAMP_PRI_WMASK;
                    end
                end
                `PIAMP_OFF_DEFPRIO: begin
                    if (pstrb[0]) begin
                        s_next.def_prio = pwdata[2:0];
                    end
                end
                `PIAMP_OFF_BYTE_EN: begin
                    if (pstrb[1]) begin
                        s_next.byte_en[15:8] = pwdata[15:8];
                    end
                    // A launch while busy is ignored; the flags tell why
                    if (pstrb[0]) begin
                        s_next.byte_en[7:0] = pwdata[7:0];
                        if (s_reg.st == piamp_pkg::PIAMP_IDLE) begin
                            s_next.st = piamp_pkg::PIAMP_RUN;
                            s_next.op_dir = s_reg.cmd[`PIAMP_CMD_DIR_BIT];
                            s_next.op_idx = s_reg.cmd[`PIAMP_CMD_IDX_MSB:0];
                            if (s_reg.cmd[`PIAMP_CMD_DIR_BIT]) begin
                                s_next.cmd[`PIAMP_CMD_WS_BIT] = 1'b0;
                            end else begin
                                s_next.cmd[`PIAMP_CMD_RS_BIT] = 1'b0;
                            end
                        end
                    end
                end
                default: begin
                    for (int k = 0; k < `PIAMP_DATA_WORDS; k++) begin
                        if (paddr == `PIAMP_OFF_DATA0 + 12'(4*k)) begin
                            for (int b = 0; b < 4; b++) begin
                                if (pstrb[b]) begin
                                    s_next.data[96-32*k+8*b +: 8] =
                                        pwdata[8*b +: 8];
                                end
                            end
                        end
                    end
                end
            endcase
        end

        // Mirroring marks; the global enable comes from the mirror_global_en input, not a register
        s_next.rx_mon = rx_pkt && mirror_global_en &&
            s_reg.mirror[`PIAMP_MIR_RX_BIT];
        s_next.tx_mon = tx_pkt && mirror_global_en &&
            s_reg.mirror[`PIAMP_MIR_TX_BIT];
        s_next.sniffer = s_reg.mirror[`PIAMP_MIR_SNIF_BIT];

        s_next.pkt_prio_valid = ingress_pkt;
        if (ingress_pkt) begin
            s_next.pkt_prio = class_prio;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;
            s_reg.st <= piamp_pkg::PIAMP_IDLE;
            s_reg.op_cnt <= `PIAMP_ACL_OP_CYCLES;
            s_reg.cmd <= `PIAMP_CMD_RST;
            s_reg.mirror <= `PIAMP_MIR_RST;
            s_reg.prio_ctl <= `PIAMP_PRI_RST;
            s_reg.def_prio <= `PIAMP_DEFPRIO_RST;
            s_reg.byte_en <= `PIAMP_BYTE_EN_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    assign prdata = s_reg.prdata;
    assign pready = s_reg.pready;
    assign pslverr = s_reg.pslverr;
    assign rx_monitored = s_reg.rx_mon;
    assign tx_monitored = s_reg.tx_mon;
    assign sniffer_port_en = s_reg.sniffer;
    assign pkt_prio = s_reg.pkt_prio;
    assign pkt_prio_valid = s_reg.pkt_prio_valid;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic be_lo_wr;
    logic run_w;
    logic run_r;
    assign be_lo_wr = wr_acc && paddr == `PIAMP_OFF_BYTE_EN && pstrb[0];
    // A launch shows as the entry into RUN
    assign run_w = s_reg.st == piamp_pkg::PIAMP_RUN && s_reg.op_dir;
    assign run_r = s_reg.st == piamp_pkg::PIAMP_RUN && !s_reg.op_dir;

    sequence wr_pending_s;
        (!s_reg.cmd[`PIAMP_CMD_WS_BIT])[*5] ##1 s_reg.cmd[`PIAMP_CMD_WS_BIT];
    endsequence
    sequence rd_pending_s;
        (!s_reg.cmd[`PIAMP_CMD_RS_BIT])[*5] ##1 s_reg.cmd[`PIAMP_CMD_RS_BIT];
    endsequence

    write_status_a: assert property (
        $rose(run_w) |-> wr_pending_s)
        else $error("write status not cleared then set after 5 cycles");
    read_status_a: assert property (
        $rose(run_r) |-> rd_pending_s)
        else $error("read status not cleared then set after 5 cycles");
    acl_launch_a: assert property (
        be_lo_wr && s_reg.st == piamp_pkg::PIAMP_IDLE |=>
        s_reg.st == piamp_pkg::PIAMP_RUN &&
        s_reg.op_idx == $past(s_reg.cmd[3:0]))
        else $error("byte enable write did not launch access");
    cmd_fields_a: assert property (
        wr_acc && paddr == `PIAMP_OFF_CMD && pstrb[0] |=>
        s_reg.cmd[4:0] == $past(pwdata[4:0]))
        else $error("command fields not stored");
    rx_sniff_a: assert property (
        rx_pkt && mirror_global_en && s_reg.mirror[`PIAMP_MIR_RX_BIT] |=>
        rx_monitored)
        else $error("received packet not marked monitored");
    tx_sniff_a: assert property (
        tx_pkt && mirror_global_en && s_reg.mirror[`PIAMP_MIR_TX_BIT] |=>
        tx_monitored)
        else $error("transmitted packet not marked monitored");
    sniffer_port_a: assert property (
        sniffer_port_en == $past(s_reg.mirror[`PIAMP_MIR_SNIF_BIT]))
        else $error("sniffer enable does not follow its bit");
    highest_prio_a: assert property (
        ingress_pkt && mac_valid &&
        s_reg.prio_ctl[`PIAMP_PRI_HI_BIT] &&
        s_reg.prio_ctl[`PIAMP_PRI_MAC_BIT] |=>
        pkt_prio >= $past(mac_prio))
        else $error("highest priority mode picked a lower value");
    or_prio_a: assert property (
        ingress_pkt && dscp_valid &&
        !s_reg.prio_ctl[`PIAMP_PRI_HI_BIT] &&
        s_reg.prio_ctl[`PIAMP_PRI_OR_BIT] &&
        s_reg.prio_ctl[`PIAMP_PRI_DSCP_BIT] |=>
        (pkt_prio & $past(dscp_prio)) == $past(dscp_prio))
        else $error("OR mode lost Diffserv priority bits");
    default_prio_a: assert property (
        ingress_pkt && s_reg.prio_ctl[4:0] == 5'h00 |=>
        pkt_prio_valid && pkt_prio == $past(s_reg.def_prio))
        else $error("default priority not applied");
    unmapped_err_a: assert property (setup && !mapped(paddr) |=>
        pready && pslverr)
        else $error("unmapped address not answered with error");

endmodule : piamp_regs

// >>> tb/piamp_regs_tb.sv
// Self-checking bench for the per-port register bank
`timescale 1ns/1ps
`include "piamp_cfg.svh"

module piamp_regs_tb;
    typedef struct packed {
        logic [11:0] a;
        logic [31:0] wd;
        logic [31:0] exp;
        logic err;
    } piamp_rrow_t;
    typedef struct packed {
        logic [7:0] ctl;
        logic [4:0] v;
        logic [2:0] exp;
    } piamp_crow_t;

    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic mirror_global_en, rx_pkt, tx_pkt, ingress_pkt, er;
    logic rx_monitored, tx_monitored, sniffer_port_en, pkt_prio_valid;
    logic [4:0] sv;
    logic [2:0] sp [5];
    logic [2:0] pkt_prio;
    int fails, comparisons;
    // Bits out of range of a register read back as zero
    piamp_rrow_t rrows [5] = '{
        '{`PIAMP_OFF_CMD, 32'h000000ff, 32'h0000007f, 1'b0},
        '{`PIAMP_OFF_MIRROR, 32'h000000ff, 32'h00000062, 1'b0},
        '{`PIAMP_OFF_PRIO, 32'h000000ff, 32'h000000df, 1'b0},
        '{`PIAMP_OFF_DEFPRIO, 32'h000000ff, 32'h00000007, 1'b0},
        '{12'h100, 32'h000000ff, 32'h00000000, 1'b1}};
    // Candidates: mac 1, vlan 2, tag 6, dscp 3, acl 5; default 7
    piamp_crow_t crows [12] = '{
        // Single-bit rows keep the advised use; the last four mix on purpose
        '{8'h00, 5'h1f, 3'h7}, '{8'h10, 5'h1f, 3'h1},
        '{8'h08, 5'h1f, 3'h2}, '{8'h04, 5'h1f, 3'h6},
        '{8'h02, 5'h1f, 3'h3}, '{8'h01, 5'h1f, 3'h5},
        '{8'h01, 5'h0f, 3'h7}, '{8'h10, 5'h1e, 3'h7},
        '{8'h9f, 5'h1f, 3'h6}, '{8'h5f, 5'h1f, 3'h7},
        '{8'h1f, 5'h1f, 3'h5}, '{8'h1e, 5'h1f, 3'h3}};

    piamp_regs u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mirror_global_en(mirror_global_en), .rx_pkt(rx_pkt),
        .tx_pkt(tx_pkt), .rx_monitored(rx_monitored),
        .tx_monitored(tx_monitored), .sniffer_port_en(sniffer_port_en),
        .ingress_pkt(ingress_pkt), .mac_valid(sv[0]), .mac_prio(sp[0]),
        .vlan_valid(sv[1]), .vlan_prio(sp[1]), .tag_valid(sv[2]),
        .tag_prio(sp[2]), .dscp_valid(sv[3]), .dscp_prio(sp[3]),
        .acl_valid(sv[4]), .acl_prio(sp[4]), .pkt_prio(pkt_prio),
        .pkt_prio_valid(pkt_prio_valid)
    );

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_val

    task automatic chk_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_bit

    task automatic tally_and_finish;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    // Request held until pready is seen; data taken at that same edge
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) fails++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdr(input logic [11:0] a);
        apb(1'b0, a, 32'h00000000, 4'h0);
    endtask : rdr

    task automatic poll(input int b);
        int n;
        n = 0;
        do begin
            rdr(`PIAMP_OFF_CMD);
            n++;
        end while (rd[b] !== 1'b1 && n < 20);
        if (n >= 20) fails++;
    endtask : poll

    task automatic pkt(input logic erx, input logic etx);
        @(posedge pclk);
        rx_pkt <= 1'b1;
        tx_pkt <= 1'b1;
        @(posedge pclk);
        rx_pkt <= 1'b0;
        tx_pkt <= 1'b0;
        #1;
        chk_bit(rx_monitored, erx);
        chk_bit(tx_monitored, etx);
        @(posedge pclk);
        #1;
        chk_val({rx_monitored, tx_monitored}, 32'h0);
    endtask : pkt

    function automatic logic [31:0] pat(input int k);
        pat = {8'(8'h40 + 4 * k), 8'(8'h41 + 4 * k),
               8'(8'h42 + 4 * k), 8'(8'h43 + 4 * k)};
    endfunction : pat

    initial begin
        #100000;
        fails++;
        tally_and_finish();
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'h0;
        mirror_global_en = 1'b1;
        rx_pkt = 1'b0;
        tx_pkt = 1'b0;
        ingress_pkt = 1'b0;
        sv = 5'h00;
        sp = '{3'h1, 3'h2, 3'h6, 3'h3, 3'h5};
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rdr(`PIAMP_OFF_CMD);
        chk_val(rd, 32'h00000060);
        for (int i = 1; i < 5; i++) begin
            rdr(12'(4 * i));
            chk_val(rd, 32'h0);
        end
        $display("test reset values done");
        foreach (rrows[i]) begin
            apb(1'b1, rrows[i].a, rrows[i].wd, 4'hf);
            rdr(rrows[i].a);
            chk_val(rd, rrows[i].exp);
            chk_bit(er, rrows[i].err);
        end
        $display("test register access done");
        apb(1'b1, `PIAMP_OFF_DEFPRIO, 32'h7, 4'h1);
        foreach (crows[i]) begin
            apb(1'b1, `PIAMP_OFF_PRIO, {24'h0, crows[i].ctl}, 4'h1);
            @(posedge pclk);
            sv <= crows[i].v;
            ingress_pkt <= 1'b1;
            @(posedge pclk);
            ingress_pkt <= 1'b0;
            #1;
            chk_bit(pkt_prio_valid, 1'b1);
            chk_val(32'(pkt_prio), 32'(crows[i].exp));
        end
        $display("test classification done");
        apb(1'b1, `PIAMP_OFF_CMD, 32'h15, 4'h1);
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, `PIAMP_OFF_DATA0 + 12'(4 * k), pat(k), 4'hf);
        end
        // Launch comes from the low enable lane only
        apb(1'b1, `PIAMP_OFF_BYTE_EN, 32'h0000ffff, 4'h3);
        rdr(`PIAMP_OFF_CMD);
        chk_val(rd, 32'h00000035);
        poll(6);
        chk_val(rd, 32'h00000075);
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, `PIAMP_OFF_DATA0 + 12'(4 * k), 32'h0, 4'hf);
        end
        apb(1'b1, `PIAMP_OFF_CMD, 32'h05, 4'h1);
        apb(1'b1, `PIAMP_OFF_BYTE_EN, 32'h000000ff, 4'h3);
        rdr(`PIAMP_OFF_CMD);
        chk_val(rd, 32'h00000045);
        poll(5);
        chk_val(rd, 32'h00000065);
        for (int k = 0; k < 4; k++) begin
            rdr(`PIAMP_OFF_DATA0 + 12'(4 * k));
            chk_val(rd, (k < 2) ? 32'h0 : pat(k));
        end
        $display("test table access done");
        apb(1'b1, `PIAMP_OFF_MIRROR, 32'h62, 4'h1);
        @(posedge pclk);
        #1;
        chk_bit(sniffer_port_en, 1'b1);
        pkt(1'b1, 1'b1);
        apb(1'b1, `PIAMP_OFF_MIRROR, 32'h40, 4'h1);
        pkt(1'b1, 1'b0);
        apb(1'b1, `PIAMP_OFF_MIRROR, 32'h20, 4'h1);
        pkt(1'b0, 1'b1);
        chk_bit(sniffer_port_en, 1'b0);
        @(posedge pclk);
        mirror_global_en <= 1'b0;
        apb(1'b1, `PIAMP_OFF_MIRROR, 32'h62, 4'h1);
        pkt(1'b0, 1'b0);
        $display("test mirroring done");
        // Reset lands while a table write runs and must restore both flags
        apb(1'b1, `PIAMP_OFF_CMD, 32'h10, 4'h1);
        apb(1'b1, `PIAMP_OFF_BYTE_EN, 32'h0, 4'h1);
        rdr(`PIAMP_OFF_CMD);
        chk_val(rd, 32'h00000030);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        #1;
        chk_bit(sniffer_port_en, 1'b0);
        @(posedge pclk);
        presetn <= 1'b1;
        rdr(`PIAMP_OFF_CMD);
        chk_val(rd, 32'h00000060);
        $display("test mid-run reset done");
        tally_and_finish();
    end
endmodule : piamp_regs_tb
